//--- verilog/intc_host_regs.svh
`ifndef INTC_HOST_REGS_SVH
`define INTC_HOST_REGS_SVH
// Register-select values seen by the device
`define SEL_EVEN 1'b0
`define SEL_ODD 1'b1
// Opcode returned on the first call-mode pulse
`define CALL_OPCODE 8'hcd
// Pulses per acknowledge sequence
`define CALL_PULSES 2'h3
`define TYPE_PULSES 2'h2
// Strobe low time and gap, in ns, and cycles at 10 ns
`define STROBE_NS 100
`define STROBE_CYC (((`STROBE_NS) + 9) / 10)
`define GAP_NS 50
`define GAP_CYC (((`GAP_NS) + 9) / 10)
`endif

//--- verilog/intc_host_pkg.sv
package intc_host_pkg;
  typedef enum logic [2:0] {
    IDLE = 3'b000,
    LOW = 3'b001,
    SAMPLE = 3'b011,
    GAP = 3'b010
  } phase_type;
  typedef enum logic [1:0] {
    OP_WRITE = 2'h0,
    OP_READ = 2'h1,
    OP_ACK = 2'h2
  } op_type;
endpackage

//--- verilog/strobe_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "intc_host_regs.svh"
module strobe_timer
  import intc_host_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic load,
  input wire logic [7:0] count,
  output logic done
);
  logic [7:0] left;
  // Down counter, done when it reaches one
  always_ff @(posedge mclk)
  begin
    if (reset)
      left <= 8'h00;
    else if (load)
      left <= count;
    else if (left != 8'h00)
      left <= left - 8'h01;
  end
  assign done = (left == 8'h01);
endmodule
`default_nettype wire

//--- verilog/intc_host_ctrl.sv
// How it works
// - Host holds command data stable on the bus during the write strobe.
// - Request inputs come from outside; host passes them through a two-flop synchroniser only.
// - Host issues acknowledge pulses and samples vector bytes during them.
// - Software picks call or type mode; host follows the chosen mode.
// - Call mode sends exactly three acknowledge pulses.
`timescale 1ns/1ps
`default_nettype none
`include "intc_host_regs.svh"
module intc_host_ctrl
  import intc_host_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  // User side
  input wire logic start,
  input wire logic [1:0] op,
  input wire logic selOdd,
  input wire logic [7:0] writeData,
  input wire logic typeMode,
  output logic busy,
  output logic [7:0] readData,
  output logic [15:0] vectorAddr,
  output logic [7:0] vectorType,
  output logic vectorValid,
  output logic opcodeError,
  output logic irqPending,
  output logic cascadeValid,
  output logic [2:0] cascadeSeen,
  output logic slaveSelSeen,
  // Device pins
  output logic chip_sel_n,
  output logic write_n,
  output logic read_n,
  output logic irq_ack_n,
  output logic register_select,
  input wire logic [7:0] host_data_bus_in,
  output logic [7:0] host_data_bus_out,
  output logic host_data_bus_oe_n,
  input wire logic [2:0] cascade_id_lines,
  input wire logic slave_sel_or_buffer_enable,
  input wire logic dev_int
);
  phase_type phase;
  phase_type next_phase;
  op_type curOp;
  logic [1:0] pulse;
  logic [7:0] dataMeta, dataSync;
  logic [2:0] casMeta;
  logic spMeta, intMeta, intSync;
  logic loadTimer, timerDone, lastPulse, takeStart;
  logic [7:0] timerCount;

  // two-flop synchronisers for asynchronous device pins
  always_ff @(posedge mclk)
  begin
    dataMeta <= host_data_bus_in;
    dataSync <= dataMeta;
    casMeta <= cascade_id_lines;
    cascadeSeen <= casMeta;
    spMeta <= slave_sel_or_buffer_enable;
    slaveSelSeen <= spMeta;
    intMeta <= dev_int;
    intSync <= intMeta;
  end

  assign irqPending = intSync;
  // cascade lines valid only from a master
  assign cascadeValid = slaveSelSeen;

  // Start acceptance, timer reload and busy
  assign takeStart = (phase == IDLE) && start && (op != 2'h3);
  assign lastPulse = typeMode ? (pulse == `TYPE_PULSES - 2'h1)
                              : (pulse == `CALL_PULSES - 2'h1);
  assign loadTimer = takeStart || (next_phase != phase);
  assign timerCount = (next_phase == GAP) ? 8'(`GAP_CYC) : 8'(`STROBE_CYC + 2);
  assign busy = (phase != IDLE);

  strobe_timer timer (
    .mclk(mclk),
    .reset(reset),
    .load(loadTimer),
    .count(timerCount),
    .done(timerDone)
  );

  // Phase sequencing
  always_comb
  begin
    next_phase = phase;
    unique case (phase)
      IDLE: if (takeStart) next_phase = LOW;
      LOW: if (timerDone) next_phase = SAMPLE;
      SAMPLE: next_phase = GAP;
      GAP:
        if (timerDone)
          next_phase = (curOp == OP_ACK && !lastPulse) ? LOW : IDLE;
      default: next_phase = IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      phase <= IDLE;
    else
      phase <= next_phase;
  end

  // Operation latch and pulse counter
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      curOp <= OP_WRITE;
      pulse <= 2'h0;
    end
    else if (takeStart)
    begin
      curOp <= op_type'(op);
      pulse <= 2'h0;
    end
    else if (phase == GAP && timerDone && curOp == OP_ACK)
      pulse <= lastPulse ? 2'h0 : pulse + 2'h1;
  end

  // Pin drive: chip select only on register access
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      chip_sel_n <= 1'b1;
      write_n <= 1'b1;
      read_n <= 1'b1;
      irq_ack_n <= 1'b1;
      host_data_bus_oe_n <= 1'b1;
      host_data_bus_out <= 8'h00;
      register_select <= `SEL_EVEN;
    end
    else
    begin
      if (takeStart)
      begin
        register_select <= selOdd;
        host_data_bus_out <= writeData;
      end
      chip_sel_n <= !((next_phase == LOW || next_phase == SAMPLE) &&
                      (takeStart ? op != OP_ACK : curOp != OP_ACK));
      write_n <= !(next_phase inside {LOW, SAMPLE} &&
                   (takeStart ? op == OP_WRITE : curOp == OP_WRITE));
      read_n <= !(next_phase inside {LOW, SAMPLE} &&
                  (takeStart ? op == OP_READ : curOp == OP_READ));
      irq_ack_n <= !(next_phase inside {LOW, SAMPLE} &&
                     (takeStart ? op == OP_ACK : curOp == OP_ACK));
      host_data_bus_oe_n <= !(next_phase != IDLE &&
                              (takeStart ? op == OP_WRITE : curOp == OP_WRITE));
    end
  end

  // Capture of returned bytes in SAMPLE
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      readData <= 8'h00;
      vectorAddr <= 16'h0000;
      vectorType <= 8'h00;
      vectorValid <= 1'b0;
      opcodeError <= 1'b0;
    end
    else
    begin
      vectorValid <= 1'b0;
      if (takeStart && op == OP_ACK)
        opcodeError <= 1'b0;
      if (phase == SAMPLE && curOp == OP_READ)
        readData <= dataSync;
      if (phase == SAMPLE && curOp == OP_ACK)
      begin
        if (typeMode)
        begin
          if (pulse == 2'h1)
          begin
            vectorType <= dataSync;
            vectorValid <= 1'b1;
          end
        end
        else
        begin
          if (pulse == 2'h0 && dataSync != `CALL_OPCODE)
            opcodeError <= 1'b1;
          if (pulse == 2'h1)
            vectorAddr[7:0] <= dataSync;
          if (pulse == 2'h2)
          begin
            vectorAddr[15:8] <= dataSync;
            vectorValid <= 1'b1;
          end
        end
      end
    end
  end

  // Checks
  chip_sel_ack_a: assert property (@(posedge mclk) disable iff (reset)
    !irq_ack_n |-> chip_sel_n) else $error("chip select during acknowledge");
  bus_release_a: assert property (@(posedge mclk) disable iff (reset)
    !read_n |-> host_data_bus_oe_n) else $error("bus driven during read");
  write_hold_a: assert property (@(posedge mclk) disable iff (reset)
    $fell(write_n) |-> !host_data_bus_oe_n [*3]) else $error("write data not held");
  read_cs_a: assert property (@(posedge mclk) disable iff (reset)
    !read_n |-> !chip_sel_n) else $error("read without chip select");
  strobe_excl_a: assert property (@(posedge mclk) disable iff (reset)
    !(!read_n && !write_n)) else $error("read and write together");
  pulse_bound_a: assert property (@(posedge mclk) disable iff (reset)
    pulse != 2'h3) else $error("pulse counter overrun");
  call_valid_a: assert property (@(posedge mclk) disable iff (reset)
    vectorValid && !typeMode |-> $past(pulse) == 2'h2) else $error("call vector early");
  type_valid_a: assert property (@(posedge mclk) disable iff (reset)
    vectorValid && typeMode |-> $past(pulse) == 2'h1) else $error("type vector wrong");
  ack_cover: cover property (@(posedge mclk) vectorValid);
  write_cover: cover property (@(posedge mclk) $fell(write_n));
  read_cover: cover property (@(posedge mclk) $fell(read_n));
endmodule
`default_nettype wire

//--- tb/vec_device_model.sv
`timescale 1ns/1ps
`default_nettype none
module vec_device_model (
  input wire logic rst,
  input wire logic csN,
  input wire logic wrN,
  input wire logic rdN,
  input wire logic ackN,
  input wire logic sel,
  input wire logic [7:0] dOut,
  input wire logic oeN,
  input wire logic tm,
  input wire logic sp8,
  input wire logic [2:0] lvl,
  input wire logic [15:0] base,
  input wire logic req,
  input wire logic badOp,
  output logic irq,
  output logic [7:0] dIn,
  output int nAck
);
  logic [7:0] cmd [2];
  logic [15:0] addr;
  logic [1:0] pulse = 2'h0;
  logic rdEn;
  logic ackEn;
  assign irq = req;
  assign addr = sp8 ? {base[15:6], lvl, 3'h0} : {base[15:5], lvl, 2'h0};
  assign rdEn = !rdN && !csN;
  assign ackEn = !ackN && (!tm || pulse == 2'h1);
  assign dIn = !oeN ? dOut : rdEn ? cmd[sel] : !ackEn ? ~dOut : tm ? {base[7:3], lvl} :
    pulse == 2'h0 ? (badOp ? 8'hcc : 8'hcd) : // Released: inverted
    pulse == 2'h1 ? addr[7:0] : addr[15:8];
  always @*
    if (!wrN && !csN)
      cmd[sel] = dIn;
  // pulse index restart, advance on acknowledge release
  always @(posedge ackN or posedge rst)
    if (rst)
      pulse = 2'h0;
    else
      pulse = pulse == (tm ? 2'h1 : 2'h2) ? 2'h0 : pulse + 2'h1;
  // Pulses seen in total
  initial nAck = 0;
  always @(negedge ackN)
    nAck = nAck + 1;
endmodule
`default_nettype wire

//--- tb/interrupt_host_port_vectoring_test.sv
`timescale 1ns/1ps
`default_nettype none
module interrupt_host_port_vectoring_test;
  import intc_host_pkg::*;
  logic mclk = 1'b0, reset = 1'b1, start = 1'b0, selOdd = 1'b0, typeMode = 1'b0;
  logic slave_sel_or_buffer_enable = 1'b1, request = 1'b0, spacing8 = 1'b0, corruptOp = 1'b0;
  logic [1:0] op = 2'h0;
  logic [2:0] cascade_id_lines = 3'h0, level = 3'h0, cascadeSeen;
  logic [7:0] writeData = 8'h00, readData, vectorType, host_data_bus_in, host_data_bus_out;
  logic [15:0] base = 16'h0000, vectorAddr;
  logic busy, vectorValid, opcodeError, irqPending, cascadeValid, slaveSelSeen, dev_int;
  logic chip_sel_n, write_n, read_n, irq_ack_n, register_select, host_data_bus_oe_n;
  int ackCount, errors = 0, nChecks = 0, cycles = 0, nValid = 0;
  intc_host_ctrl dut_u (.mclk, .reset, .start, .op, .selOdd, .writeData, .typeMode,
    .busy, .readData, .vectorAddr, .vectorType, .vectorValid, .opcodeError, .irqPending,
    .cascadeValid, .cascadeSeen, .slaveSelSeen, .chip_sel_n, .write_n, .read_n,
    .irq_ack_n, .register_select, .host_data_bus_in, .host_data_bus_out,
    .host_data_bus_oe_n, .cascade_id_lines, .slave_sel_or_buffer_enable, .dev_int);
  vec_device_model dev_u (.rst(reset), .csN(chip_sel_n), .wrN(write_n), .rdN(read_n),
    .ackN(irq_ack_n), .sel(register_select), .dOut(host_data_bus_out),
    .oeN(host_data_bus_oe_n), .tm(typeMode), .sp8(spacing8), .lvl(level), .base(base),
    .req(request), .badOp(corruptOp), .irq(dev_int), .dIn(host_data_bus_in), .nAck(ackCount));
  // Clock
  always #5 mclk = ~mclk;
  // Count one-cycle vector valid pulses
  always @(posedge mclk)
    if (vectorValid === 1'b1)
      nValid++;
  // Hang guard
  always @(posedge mclk)
    if (++cycles == 2000)
    begin
      errors++;
      summarize();
    end
  // Verdict and end of run
  task automatic summarize();
    if (errors == 0 && nChecks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Compare and count
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    nChecks++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One user request, bounded wait for busy to drop
  task automatic run(input op_type o, input logic s, input logic [7:0] d);
    op <= o;
    selOdd <= s;
    writeData <= d;
    start <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    for (int n = 0; n < 200 && (n < 2 || busy); n++)
      @(posedge mclk);
    check(busy, 16'h0000);
  endtask
  // Back-to-back writes on both selects, then read back
  task automatic regAccess();
    run(OP_WRITE, 1'b0, 8'h5a);
    run(OP_WRITE, 1'b1, 8'ha5);
    run(OP_READ, 1'b0, 8'h00);
    check(readData, 16'h005a);
    run(OP_READ, 1'b1, 8'h00);
    check(readData, 16'h00a5);
  endtask
  // Device status pins seen through their syncs
  task automatic pins();
    // request held high through all acknowledges
    request <= 1'b1;
    cascade_id_lines <= 3'h6;
    slave_sel_or_buffer_enable <= 1'b0;
    repeat (5) @(posedge mclk);
    check(irqPending, 16'h0001);
    check(cascadeSeen, 16'h0006);
    check(slaveSelSeen, 16'h0000);
    check(cascadeValid, 16'h0000);
    slave_sel_or_buffer_enable <= 1'b1;
    repeat (5) @(posedge mclk);
    check(slaveSelSeen, 16'h0001);
    check(cascadeValid, 16'h0001);
  endtask
  // Wrong first call byte must raise the opcode flag
  task automatic badCall();
    corruptOp <= 1'b1;
    typeMode <= 1'b0;
    run(OP_ACK, 1'b0, 8'h00);
    check(opcodeError, 16'h0001);
    corruptOp <= 1'b0;
  endtask
  // Acknowledge sequence in either mode
  task automatic ack(input logic tm, sp, input logic [2:0] lv, input logic [15:0] b);
    int c0, v0;
    c0 = ackCount;
    v0 = nValid;
    typeMode <= tm;
    spacing8 <= sp;
    level <= lv;
    base <= b;
    run(OP_ACK, 1'b0, 8'h00);
    check(16'(ackCount - c0), tm ? 16'h0002 : 16'h0003);
    check(16'(nValid - v0), 16'h0001);
    if (tm)
      check(vectorType, {8'h00, b[7:3], lv});
    else if (sp)
      check(vectorAddr, {b[15:6], lv, 3'h0});
    else
      check(vectorAddr, {b[15:5], lv, 2'h0});
    check(opcodeError, 16'h0000);
  endtask
  // Reset, then each scenario in turn
  initial
  begin
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    regAccess();
    pins();
    ack(1'b0, 1'b0, 3'h7, 16'h1234);
    ack(1'b0, 1'b1, 3'h5, 16'habcd);
    ack(1'b1, 1'b0, 3'h3, 16'h00f8);
    ack(1'b0, 1'b0, 3'h0, 16'hffff);
    badCall();
    ack(1'b1, 1'b0, 3'h6, 16'h0040);
    summarize();
  end
endmodule
`default_nettype wire
